// ==== rtl/tone_pkg.sv ====
/*
 * Shared constants and types of the acoustic indicator tone generator.
 * Assumes one 25 MHz system clock and a synchronous, active-low reset.
 */
// What this block does
// - ten events, each with its own sound
// - sound is all pure or all damped
// - pure sound: up to four configured tones
// - pure tones fade in and out, 64 ms
// - start time marks beginning of fade-in
// - duration counted from fade-in start
// - damped sound: up to six tones, decay
// - damped tone jumps full, decays exponentially
// - normal audio attenuated, indicator added on top
// - 20-bit samples at 32 or 16 kHz
package tone_pkg;
    ////////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_HZ      = 25_000_000;
    localparam int RATE_HI_HZ  = 32_000;
    localparam int RATE_LO_HZ  = 16_000;
    localparam int MS_PER_S    = 1000;
    localparam int RAMP_MS     = 64;
    localparam int DIV_HI      = CLK_HZ / RATE_HI_HZ;    // rounds down, 781 cycles
    localparam int DIV_LO      = CLK_HZ / RATE_LO_HZ;    // 1562 cycles
    localparam int SPMS_HI     = RATE_HI_HZ / MS_PER_S;  // samples per millisecond
    localparam int SPMS_LO     = RATE_LO_HZ / MS_PER_S;

    ////////////////////////////////////////////////////////////////////////////////
    // sizes
    localparam int NUM_EVENTS  = 10;
    localparam int PURE_MAX    = 4;
    localparam int DAMP_MAX    = 6;
    localparam int SAMPLE_W    = 20;
    localparam int ADDR_W      = 11;
    localparam int DATA_W      = 16;
    localparam int FIFO_DEPTH  = 16;

    ////////////////////////////////////////////////////////////////////////////////
    // register map: config words at {event, component, field}, then two registers
    localparam logic [ADDR_W-1:0] CFG_LIMIT   = 11'h400;
    localparam logic [ADDR_W-1:0] CTRL_ADDR   = 11'h400;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 11'h401;
    localparam logic [2:0] FLD_FREQ  = 3'h0;
    localparam logic [2:0] FLD_AMP   = 3'h1;
    localparam logic [2:0] FLD_START = 3'h2;
    localparam logic [2:0] FLD_DUR   = 3'h3;
    localparam logic [2:0] FLD_DECAY = 3'h4;
    localparam logic [2:0] FLD_HDR   = 3'h5;
    localparam int HDR_DAMPED_BIT  = 0;
    localparam int HDR_COUNT_LSB   = 1;
    localparam int CTRL_RATE_LO_BIT = 0;
    localparam int CTRL_GAIN_LSB   = 8;
    localparam logic [DATA_W-1:0] CTRL_RESET = 16'h8000;
    localparam logic [15:0] ENV_FULL = 16'hFFFF;

    ////////////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic [15:0] freqInc;
        logic [15:0] amp;
        logic [15:0] startMs;
        logic [15:0] durMs;
        logic [15:0] decay;
    } comp_param_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } bus_req_t;

    typedef struct packed {
        logic                valid;
        logic [SAMPLE_W-1:0] data;
    } audio_smp_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_LOAD = 4'b0010,
        ST_PLAY = 4'b0100,
        ST_MIX  = 4'b1000
    } state_t;
endpackage

// ==== rtl/acoustic_indicator_tone_gen.sv ====
/*
 * Indicator tone generator with its audio FIFO.
 * Assumes event triggers and audio input come from logic on clk_sys.
 */
// Design decisions made here: the register offsets and the strobed register port.

////////////////////////////////////////////////////////////////////////////////
// audio FIFO: the drain pops once per sample, so a fast source really fills it
module sample_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_sys,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic      [WIDTH-1:0] outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wrPtr_r;
    logic [PW-1:0]    rdPtr_r;
    logic [PW:0]      count_r;
    logic             push;
    logic             pop;

    assign inReady  = (count_r != (PW+1)'(DEPTH));
    assign outValid = (count_r != '0);
    assign outData  = mem[rdPtr_r];
    assign push     = inValid & inReady;
    assign pop      = outReady & outValid;

    // storage has no reset, only the pointers and the fill level do
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wrPtr_r] <= inData;
        end
    end

    // pointers and fill level
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) wrPtr_r <= (wrPtr_r == PW'(DEPTH-1)) ? '0 : wrPtr_r + 1'b1;
            if (pop)  rdPtr_r <= (rdPtr_r == PW'(DEPTH-1)) ? '0 : rdPtr_r + 1'b1;
            count_r <= count_r + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule // sample_fifo

////////////////////////////////////////////////////////////////////////////////
module acoustic_indicator_tone_gen #(
    parameter int NUM_COMP = tone_pkg::DAMP_MAX
) (
    input  wire logic                              clk_sys,
    input  wire logic                              rstn,
    input  wire logic [tone_pkg::NUM_EVENTS-1:0]   eventTrig,
    input  wire tone_pkg::bus_req_t                busReq,
    output logic      [tone_pkg::DATA_W-1:0]       busRdata,
    input  wire logic [tone_pkg::SAMPLE_W-1:0]     audioIn,
    input  wire logic                              audioInValid,
    output logic                                   audioInReady,
    output tone_pkg::audio_smp_t                   audioOut,
    output logic                                   playing
);
    localparam int SW = tone_pkg::SAMPLE_W;

    // parabolic sine: within a few percent of a true sine, no table needed
    function automatic logic signed [15:0] waveOf(input logic [15:0] p);
        logic [14:0] x;
        logic [30:0] y;
        logic [15:0] m;
        x = p[14:0];
        y = 31'(x) * 31'(16'h8000 - {1'b0, x});
        m = {1'b0, y[28:14]};
        return p[15] ? 16'(-m) : m;
    endfunction

    tone_pkg::state_t            state_r;
    logic [tone_pkg::DATA_W-1:0] cfgMem [1024];
    logic [tone_pkg::DATA_W-1:0] ctrl_r;
    tone_pkg::comp_param_t       compPar_r [NUM_COMP];
    logic [15:0]                 phase_r [NUM_COMP];
    logic [15:0]                 envD_r [NUM_COMP];
    logic [15:0]                 env [NUM_COMP];
    logic [NUM_COMP-1:0]         active;
    logic [NUM_COMP-1:0]         finished;
    logic [3:0]                  evt_r;
    logic [3:0]                  evtPend_r;
    logic                        trigPend_r;
    logic                        damped_r;
    logic [2:0]                  count_r;
    logic                        sndOn_r;
    logic [2:0]                  ldComp_r;
    logic [2:0]                  ldField_r;
    logic [10:0]                 divCnt_r;
    logic                        tick;
    logic                        tickPend_r;
    logic [5:0]                  spmCnt_r;
    logic [16:0]                 msCnt_r;
    logic                        msStep;
    logic [2:0]                  mixIdx_r;
    logic signed [23:0]          acc_r;
    logic signed [23:0]          accNxt;
    logic [SW-1:0]               audioHeld_r;
    logic [SW-1:0]               fifoData;
    logic                        fifoValid;
    logic                        fifoPop;
    logic                        rateLow;
    logic [3:0]                  trigIdx;
    logic [3:0]                  limit;
    logic [15:0]                 ldWord;
    logic                        mixStart;
    logic                        mixLast;

    assign rateLow  = ctrl_r[tone_pkg::CTRL_RATE_LO_BIT];
    assign limit    = damped_r ? 4'(tone_pkg::DAMP_MAX) : 4'(tone_pkg::PURE_MAX);
    assign playing  = sndOn_r;
    assign mixStart = tickPend_r & (state_r == tone_pkg::ST_IDLE || state_r == tone_pkg::ST_PLAY);
    assign mixLast  = (state_r == tone_pkg::ST_MIX) && (mixIdx_r == 3'(NUM_COMP-1));
    assign fifoPop  = mixStart;
    assign ldWord   = cfgMem[{evt_r, ldComp_r, ldField_r}];

    ////////////////////////////////////////////////////////////////////////////////
    // audio path buffer
    sample_fifo #(.WIDTH(SW), .DEPTH(tone_pkg::FIFO_DEPTH)) u_fifo (
        .clk_sys  (clk_sys),
        .rstn     (rstn),
        .inData   (audioIn),
        .inValid  (audioInValid),
        .inReady  (audioInReady),
        .outData  (fifoData),
        .outValid (fifoValid),
        .outReady (fifoPop)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // register bus: config memory below CFG_LIMIT, control at CFG_LIMIT and status just above
    always_ff @(posedge clk_sys) begin
        if (busReq.wr && busReq.addr < tone_pkg::CFG_LIMIT) begin
            cfgMem[busReq.addr[9:0]] <= busReq.wdata;
        end
    end

    // control word and registered read data
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            ctrl_r   <= tone_pkg::CTRL_RESET;
            busRdata <= '0;
        end else begin
            if (busReq.wr && busReq.addr == tone_pkg::CTRL_ADDR) ctrl_r <= busReq.wdata;
            busRdata <= '0;
            if (busReq.rd) begin
                if (busReq.addr < tone_pkg::CFG_LIMIT) busRdata <= cfgMem[busReq.addr[9:0]];
                else if (busReq.addr == tone_pkg::CTRL_ADDR) busRdata <= ctrl_r;
                else if (busReq.addr == tone_pkg::STATUS_ADDR) begin
                    busRdata <= {8'h00, evt_r, 2'b00, damped_r, sndOn_r};
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sample rate divider and millisecond step
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            divCnt_r <= '0;
            tick     <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (divCnt_r == (rateLow ? 11'(tone_pkg::DIV_LO - 1) : 11'(tone_pkg::DIV_HI - 1))) begin
                divCnt_r <= '0;
                tick     <= 1'b1;
            end else begin
                divCnt_r <= divCnt_r + 1'b1;
            end
        end
    end

    assign msStep = mixLast && (spmCnt_r == (rateLow ? 6'(tone_pkg::SPMS_LO - 1)
                                                     : 6'(tone_pkg::SPMS_HI - 1)));

    ////////////////////////////////////////////////////////////////////////////////
    // lowest-numbered trigger wins when several fire together
    always_comb begin
        trigIdx = '0;
        for (int i = tone_pkg::NUM_EVENTS - 1; i >= 0; i--) begin
            if (eventTrig[i]) trigIdx = 4'(i);
        end
    end

    // pending trigger and tick: a new arrival wins over the clear in the same cycle
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            trigPend_r <= 1'b0;
            evtPend_r  <= '0;
            tickPend_r <= 1'b0;
        end else begin
            if (state_r == tone_pkg::ST_LOAD && ldComp_r == 3'd0 && ldField_r == 3'd0) begin
                trigPend_r <= 1'b0;
            end
            if (|eventTrig) begin
                trigPend_r <= 1'b1;
                evtPend_r  <= trigIdx;
            end
            if (mixStart) tickPend_r <= 1'b0;
            if (tick) tickPend_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sequencer: audio samples first, then a fresh trigger, then end of sound
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            state_r   <= tone_pkg::ST_IDLE;
            evt_r     <= '0;
            sndOn_r   <= 1'b0;
            ldComp_r  <= '0;
            ldField_r <= '0;
            mixIdx_r  <= '0;
        end else begin
            case (state_r)
                tone_pkg::ST_IDLE, tone_pkg::ST_PLAY: begin
                    if (tickPend_r) begin
                        state_r  <= tone_pkg::ST_MIX;
                        mixIdx_r <= '0;
                    end else if (trigPend_r) begin
                        state_r   <= tone_pkg::ST_LOAD;
                        evt_r     <= evtPend_r;
                        sndOn_r   <= 1'b0;
                        ldComp_r  <= '0;
                        ldField_r <= '0;
                    end else if (sndOn_r && &finished) begin
                        state_r <= tone_pkg::ST_IDLE;
                        sndOn_r <= 1'b0;
                    end
                end
                tone_pkg::ST_LOAD: begin
                    if (ldField_r == tone_pkg::FLD_HDR) begin
                        ldField_r <= '0;
                        if (ldComp_r == 3'(NUM_COMP - 1)) begin
                            state_r <= tone_pkg::ST_PLAY;
                            sndOn_r <= 1'b1;
                        end else begin
                            ldComp_r <= ldComp_r + 1'b1;
                        end
                    end else begin
                        ldField_r <= ldField_r + 1'b1;
                    end
                end
                tone_pkg::ST_MIX: begin
                    mixIdx_r <= mixIdx_r + 1'b1;
                    if (mixLast) state_r <= sndOn_r ? tone_pkg::ST_PLAY : tone_pkg::ST_IDLE;
                end
                default: state_r <= tone_pkg::ST_IDLE;
            endcase
        end
    end

    // parameter load, one word per cycle; header lives with component 0
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            damped_r <= 1'b0;
            count_r  <= '0;
        end else if (state_r == tone_pkg::ST_LOAD) begin
            case (ldField_r)
                tone_pkg::FLD_FREQ:  compPar_r[ldComp_r].freqInc <= ldWord;
                tone_pkg::FLD_AMP:   compPar_r[ldComp_r].amp     <= ldWord;
                tone_pkg::FLD_START: compPar_r[ldComp_r].startMs <= ldWord;
                tone_pkg::FLD_DUR:   compPar_r[ldComp_r].durMs   <= ldWord;
                tone_pkg::FLD_DECAY: compPar_r[ldComp_r].decay   <= ldWord;
                default: begin
                    if (ldComp_r == 3'd0) begin
                        damped_r <= ldWord[tone_pkg::HDR_DAMPED_BIT];
                        count_r  <= ldWord[tone_pkg::HDR_COUNT_LSB +: 3];
                    end
                end
            endcase
        end
    end

    // sound clock in milliseconds since the trigger
    always_ff @(posedge clk_sys) begin
        if (!rstn || state_r == tone_pkg::ST_LOAD) begin
            msCnt_r  <= '0;
            spmCnt_r <= '0;
        end else if (mixLast && sndOn_r) begin
            spmCnt_r <= msStep ? '0 : spmCnt_r + 1'b1;
            if (msStep && !(&msCnt_r)) msCnt_r <= msCnt_r + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // per-component window, envelope and oscillator
    for (genvar k = 0; k < NUM_COMP; k++) begin : g_comp
        logic [16:0] endMs;
        logic [16:0] rel;
        logic [16:0] remain;
        logic [16:0] lvl;
        logic        used;

        assign endMs  = 17'(compPar_r[k].startMs) + 17'(compPar_r[k].durMs);
        assign rel    = msCnt_r - 17'(compPar_r[k].startMs);
        assign remain = endMs - msCnt_r;
        assign used   = sndOn_r && (k < count_r) && (k < limit);
        assign active[k]   = used && msCnt_r >= 17'(compPar_r[k].startMs) && msCnt_r < endMs;
        assign finished[k] = !used || msCnt_r >= endMs;
        assign lvl    = (rel < remain) ? rel : remain;
        // ramp moves in millisecond steps of 1/64, fine enough to avoid clicks
        assign env[k] = damped_r ? envD_r[k]
                      : (lvl >= 17'(tone_pkg::RAMP_MS)) ? tone_pkg::ENV_FULL
                      : {lvl[5:0], 10'h000};

        // damped envelope sits at full until its window opens, then decays
        always_ff @(posedge clk_sys) begin
            if (!rstn || state_r == tone_pkg::ST_LOAD) begin
                envD_r[k] <= tone_pkg::ENV_FULL;
            end else if (msStep && active[k]) begin
                envD_r[k] <= 16'((32'(envD_r[k]) * 32'(compPar_r[k].decay)) >> 16);
            end
        end

        // oscillator phase advances once per sample while sounding
        always_ff @(posedge clk_sys) begin
            if (!rstn || state_r == tone_pkg::ST_LOAD) begin
                phase_r[k] <= '0;
            end else if (mixLast && active[k]) begin
                phase_r[k] <= phase_r[k] + compPar_r[k].freqInc;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // mixer: one component per cycle shares a single multiplier pair
    always_comb begin
        logic signed [32:0] p1;
        logic signed [32:0] p2;
        p1 = 33'(waveOf(phase_r[mixIdx_r])) * $signed({17'h00000, compPar_r[mixIdx_r].amp});
        // part-selects are unsigned, so the sign is restored before widening
        p2 = 33'($signed(p1[31:16])) * $signed({17'h00000, env[mixIdx_r]});
        accNxt = acc_r;
        if (active[mixIdx_r]) accNxt = acc_r + (24'($signed(p2[32:16])) <<< 4);
    end

    // accumulator, held audio sample and the saturated output
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            acc_r       <= '0;
            audioHeld_r <= '0;
            audioOut    <= '0;
        end else begin
            audioOut.valid <= 1'b0;
            if (mixStart) begin
                acc_r       <= '0;
                audioHeld_r <= fifoValid ? fifoData : '0; // underrun plays silence
            end else if (state_r == tone_pkg::ST_MIX) begin
                acc_r <= accNxt;
            end
            if (mixLast) begin
                logic signed [29:0] att;
                logic signed [29:0] sum;
                att = 30'($signed(audioHeld_r)) * $signed({22'h000000, ctrl_r[15:8]});
                att = sndOn_r ? (att >>> 8) : 30'($signed(audioHeld_r));
                sum = att + 30'(accNxt);
                audioOut.valid <= 1'b1;
                if (sum > 30'sd524287) audioOut.data <= 20'h7FFFF;
                else if (sum < -30'sd524288) audioOut.data <= 20'h80000;
                else audioOut.data <= sum[SW-1:0];
            end
        end
    end
endmodule // acoustic_indicator_tone_gen

// ==== verif/audio_source.sv ====
/* far-side audio source feeding the tone generator's sample FIFO.
   assumes clk_sys and the synchronous active-low rstn of the block. */
module audio_source (
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic        srcOn,
    input  wire logic        ready,
    output logic             valid,
    output logic [19:0]      data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [19:0] nextSmp_r;

    // between offers the bus shows junk, never the last word
    assign data = valid ? nextSmp_r : ~nextSmp_r;

    // step of four keeps gain products exact for gains in multiples of 64; offer held until taken
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            valid     <= 1'b0;
            nextSmp_r <= 20'h01000;
        end else begin
            if (valid && ready) nextSmp_r <= nextSmp_r + 20'h00004;
            if (!valid || ready) valid <= srcOn;
        end
    end
endmodule // audio_source

// ==== verif/tone_gen_properties.sv ====
/* port checker of the indicator tone generator.
   assumes it is bound to the top module and runs on clk_sys only. */
module tone_gen_properties #(
    parameter int NUM_COMP = 6
) (
    input wire logic                            clk_sys,
    input wire logic                            rstn,
    input wire logic [tone_pkg::NUM_EVENTS-1:0] eventTrig,
    input wire tone_pkg::bus_req_t              busReq,
    input wire logic [tone_pkg::DATA_W-1:0]     busRdata,
    input wire tone_pkg::audio_smp_t            audioOut,
    input wire logic                            playing
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    logic [11:0] gapCnt_r;
    logic [15:0] ctrlCopy_r;

    // cycles since last sample; saturates so a stall cannot wrap
    always_ff @(posedge clk_sys) begin
        if (!rstn) gapCnt_r <= 12'h000;
        else if (audioOut.valid) gapCnt_r <= 12'h001;
        else if (gapCnt_r != 12'hFFF) gapCnt_r <= gapCnt_r + 12'h001;
    end

    // shadow of the control word, from what software wrote
    always_ff @(posedge clk_sys) begin
        if (!rstn) ctrlCopy_r <= tone_pkg::CTRL_RESET;
        else if (busReq.wr && busReq.addr == tone_pkg::CTRL_ADDR) ctrlCopy_r <= busReq.wdata;
    end

    ////////////////////////////////////////
    a_read_idle_zero: assert property (!$past(busReq.rd) |-> busRdata == 16'h0000)
        else $error("read data not zero outside read answer");
    a_unmapped_reads: assert property (busReq.rd && busReq.addr > tone_pkg::STATUS_ADDR
        |=> busRdata == 16'h0000) else $error("unmapped read not zero");
    a_ctrl_readback: assert property (busReq.rd && busReq.addr == tone_pkg::CTRL_ADDR
        |=> busRdata == $past(ctrlCopy_r)) else $error("control word readback wrong");
    a_status_playing: assert property (busReq.rd && busReq.addr == tone_pkg::STATUS_ADDR
        |=> busRdata[0] == $past(playing)) else $error("status play bit wrong");
    a_sample_pulse: assert property (audioOut.valid |=> !audioOut.valid)
        else $error("sample valid longer than one cycle");
    a_sample_gap_min: assert property (audioOut.valid |-> gapCnt_r >= 12'd720)
        else $error("samples too close together");
    a_sample_gap_max: assert property (gapCnt_r <= 12'd1650)
        else $error("sample stream stalled");
    a_trigger_plays: assert property (eventTrig != '0 |-> ##[1:120] playing)
        else $error("trigger did not start a sound");
endmodule // tone_gen_properties

// ==== verif/test_acoustic_indicator_tone_gen.sv ====
/* self-checking bench of the indicator tone generator.
   assumes the design package and the audio source model are compiled first. */
module test_acoustic_indicator_tone_gen;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic        wr;
        logic [10:0] addr;
        logic [15:0] wdata;
        logic [15:0] expRd;
    } row_t;
    localparam row_t ROWS [6] = '{
        '{1'b0, tone_pkg::CTRL_ADDR,   16'h0000, 16'h8000},
        '{1'b0, tone_pkg::STATUS_ADDR, 16'h0000, 16'h0000},
        '{1'b1, 11'h7FF,               16'hFFFF, 16'h0000},
        '{1'b0, 11'h7FF,               16'h0000, 16'h0000},
        '{1'b1, tone_pkg::CTRL_ADDR,   16'h4000, 16'h0000},
        '{1'b0, tone_pkg::CTRL_ADDR,   16'h0000, 16'h4000}};
    logic                 clk_sys, rstn, audioInValid, audioInReady, playing, srcOn;
    logic [9:0]           eventTrig;
    tone_pkg::bus_req_t   busReq;
    logic [15:0]          busRdata, rdVal;
    logic [19:0]          audioIn, expSmp;
    tone_pkg::audio_smp_t audioOut;
    logic [19:0]          pushQ [$];
    int                   errCount, nTests, mode;
    time                  t0;

    acoustic_indicator_tone_gen i_dut (.clk_sys(clk_sys), .rstn(rstn), .eventTrig(eventTrig),
        .busReq(busReq), .busRdata(busRdata), .audioIn(audioIn), .audioInValid(audioInValid),
        .audioInReady(audioInReady), .audioOut(audioOut), .playing(playing));
    audio_source i_src (.clk_sys(clk_sys), .rstn(rstn), .srcOn(srcOn), .ready(audioInReady),
        .valid(audioInValid), .data(audioIn));

    ////////////////////////////////////////
    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        nTests++;
        if (seen !== exp) begin
            errCount++;
            $display("FAIL %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic giveVerdict();
        if (errCount == 0 && nTests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic busWr(input logic [10:0] a, input logic [15:0] d);
        busReq.addr <= a;
        busReq.wdata <= d;
        busReq.wr <= 1'b1;
        @(posedge clk_sys);
        busReq.wr <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic busRd(input logic [10:0] a);
        busReq.addr <= a;
        busReq.rd <= 1'b1;
        @(posedge clk_sys);
        busReq.rd <= 1'b0;
        // read data stands only in the cycle after the strobe
        @(posedge clk_sys);
        rdVal = busRdata;
    endtask
    // one component: silent amplitude so the audio scaling stays exact, 1 ms long
    task automatic cfg(input logic [3:0] ev, input logic [15:0] hdr);
        logic [15:0] v [6];
        v = '{16'h0400, 16'h0000, 16'h0000, 16'h0001, 16'hF000, hdr};
        for (int f = 0; f < 6; f++) busWr({1'b0, ev, 3'h0, 3'(f)}, v[f]);
    endtask
    task automatic pulse(input logic [9:0] t);
        eventTrig <= t;
        @(posedge clk_sys);
        eventTrig <= 10'h000;
        repeat (60) @(posedge clk_sys);
    endtask
    task automatic waitPlay(input logic lvl, input int lim);
        for (int k = 0; k < lim && playing !== lvl; k++) @(posedge clk_sys);
    endtask

    ////////////////////////////////////////
    // clock
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // hang guard: the sequence needs about 56k cycles
    initial begin
        repeat (100000) @(posedge clk_sys);
        errCount++;
        giveVerdict();
    end

    // sample scoreboard; mode 2 skips samples around play edges, where scale is unsettled
    always @(posedge clk_sys) begin
        if (rstn && audioInValid && audioInReady) pushQ.push_back(audioIn);
        if (audioOut.valid) begin
            expSmp = (pushQ.size() > 0) ? pushQ.pop_front() : 20'h00000;
            if (mode == 1) expSmp = expSmp >> 2;
            if (mode < 2) check(audioOut.data, expSmp);
        end
    end

    ////////////////////////////////////////
    initial begin
        rstn = 1'b0;
        eventTrig = 10'h000;
        busReq = '0;
        srcOn = 1'b0;
        mode = 0;
        errCount = 0;
        nTests = 0;
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        srcOn <= 1'b1;
        repeat (30) @(posedge clk_sys);
        check({19'h0, audioInReady}, 20'h0);
        for (int i = 0; i < 6; i++) begin
            if (ROWS[i].wr) busWr(ROWS[i].addr, ROWS[i].wdata);
            else begin
                busRd(ROWS[i].addr);
                check({4'h0, rdVal}, {4'h0, ROWS[i].expRd});
            end
        end
        cfg(4'h3, 16'h0003);
        cfg(4'h5, 16'h0002);
        repeat (3) @(posedge audioOut.valid);
        mode = 2;
        pulse(10'h028);
        waitPlay(1'b1, 100);
        busRd(tone_pkg::STATUS_ADDR);
        check({4'h0, rdVal}, 20'h00033);
        @(posedge audioOut.valid);
        mode = 1;
        repeat (8) @(posedge audioOut.valid);
        mode = 2;
        pulse(10'h020);
        waitPlay(1'b1, 100);
        busRd(tone_pkg::STATUS_ADDR);
        check({4'h0, rdVal}, 20'h00051);
        @(posedge audioOut.valid);
        mode = 1;
        repeat (27) @(posedge audioOut.valid);
        check({19'h0, playing}, 20'h1);
        mode = 2;
        waitPlay(1'b0, 8000);
        check({19'h0, playing}, 20'h0);
        srcOn <= 1'b0;
        repeat (2) @(posedge audioOut.valid);
        mode = 0;
        repeat (20) @(posedge audioOut.valid);
        check({19'h0, audioInReady}, 20'h1);
        // low rate: the divider must space samples by the slow count
        busWr(tone_pkg::CTRL_ADDR, 16'h0001);
        repeat (2) @(posedge audioOut.valid);
        t0 = $time;
        @(posedge audioOut.valid);
        check(20'(($time - t0) / 40), 20'(tone_pkg::DIV_LO));
        giveVerdict();
    end
endmodule // test_acoustic_indicator_tone_gen

bind acoustic_indicator_tone_gen tone_gen_properties #(.NUM_COMP(NUM_COMP)) i_props (
    .clk_sys(clk_sys), .rstn(rstn), .eventTrig(eventTrig), .busReq(busReq),
    .busRdata(busRdata), .audioOut(audioOut), .playing(playing));
